// [hdl/ppc_extra_pin.v]
// Extra pin pull-up, input type and timer output routing.
// Assumes the reset-pin-disable configuration level is stable after boot.
`include "ppc_regs.vh"
module ppc_extra_pin (
    input  wire [7:0] setting,
    input  wire       reset_pin_disable_config,
    input  wire       timer0_out,
    input  wire       timer1_out,
    output wire       pullup_on,
    output wire       schmitt_on,
    output wire       timer0_pin_drive,
    output wire       timer0_pin_en,
    output wire       timer1_pin_drive,
    output wire       timer1_pin_en
);
    // A pin used as reset always keeps its pull-up; otherwise the enable bit decides.
    assign pullup_on = reset_pin_disable_config ? 1'b1 : setting[`PPC_BIT_PULLUP];
    assign schmitt_on = setting[`PPC_BIT_SCHMITT];
    // Timer outputs reach their pins only when enabled.
    assign timer1_pin_en    = setting[`PPC_BIT_TIMER1_PIN_OUTPUT_ENABLE];
    assign timer1_pin_drive = setting[`PPC_BIT_TIMER1_PIN_OUTPUT_ENABLE] & timer1_out;
    assign timer0_pin_en    = setting[`PPC_BIT_TIMER0_PIN_OUTPUT_ENABLE];
    assign timer0_pin_drive = setting[`PPC_BIT_TIMER0_PIN_OUTPUT_ENABLE] & timer0_out;
endmodule

// [hdl/ppc_pin_ctrl.v]
// Per-pin drive control for one 8-bit port, decoded from the two mode bits.
// Assumes the pad drives high when drive_high is set and low when drive_low is set.
`include "ppc_regs.vh"
module ppc_pin_ctrl (
    input  wire [7:0] mode_a,
    input  wire [7:0] mode_b,
    input  wire [7:0] out_data,
    output wire [7:0] drive_high,
    output wire [7:0] drive_low,
    output wire [7:0] weak_pullup
);
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pin
            wire [1:0] mode;
            assign mode = {mode_a[i], mode_b[i]};
            // Push-pull drives both levels; open-drain and quasi drive only low.
            assign drive_high[i]  = (mode == `PPC_MODE_PUSHPULL) & out_data[i];
            assign drive_low[i]   = ((mode == `PPC_MODE_PUSHPULL) | (mode == `PPC_MODE_QUASI) |
                                     (mode == `PPC_MODE_OPENDRAIN)) & ~out_data[i];
            // Quasi-bidirectional keeps a weak pull-up; input-only floats.
            assign weak_pullup[i] = (mode == `PPC_MODE_QUASI);
        end
    endgenerate
endmodule

// [hdl/ppc_regs.vh]
// Register map, field positions and reset values of the port pin configuration block.
// Assumes byte-wide registers reached by byte address; page select comes from a page register.
`ifndef PPC_REGS_VH
`define PPC_REGS_VH
`define PPC_OFS_P0_MODE_A     8'hb1
`define PPC_OFS_P0_MODE_B     8'hb2
`define PPC_OFS_P1_MODE_A     8'hb3
`define PPC_OFS_P1_MODE_B     8'hb4
`define PPC_OFS_EXTRA_SET     8'hb5
`define PPC_OFS_PAGE_SEL      8'hb6
`define PPC_RST_MODE_A        8'hff
`define PPC_RST_MODE_B        8'h00
`define PPC_RST_SCHMITT       8'h00
`define PPC_RST_SLEW          8'h00
`define PPC_RST_EXTRA_SET     8'h00
`define PPC_BIT_PULLUP        7
`define PPC_BIT_TIMER1_PIN_OUTPUT_ENABLE          3
`define PPC_BIT_TIMER0_PIN_OUTPUT_ENABLE          2
`define PPC_BIT_SCHMITT       0
`define PPC_EXTRA_MASK        8'h8d
`define PPC_MODE_QUASI        2'b00
`define PPC_MODE_PUSHPULL     2'b01
`define PPC_MODE_INPUT        2'b10
`define PPC_MODE_OPENDRAIN    2'b11
`endif

// [hdl/ppc_top.v]
// Port pin configuration registers for two 8-bit ports and one extra pin.
// Assumes an Avalon-MM master with byte addresses; registers sit in the low byte lane.
// Assumes every pad control and timer pin feeds the pad ring straight from a flip-flop.
//
// Chosen here: the Avalon-MM register port.

`include "ppc_regs.vh"

// Overview of operation
// - Mode pair per pin: 00 quasi, 01 push-pull, 10 input-only, 11 open-drain.
// - Port 0 mode A resets to all ones, mode B to zeros.
// - Port 1 mode A resets to all ones, mode B to zeros.
// - Addresses b1 to b4 hold page 0 mode and page 1 input/slew registers.
// - Input-type bit 0 selects TTL input, 1 selects Schmitt input.
// - Slew bit 0 selects normal slew, 1 selects high-speed slew.
// - Input-type and slew registers of both ports reset to zeros.
// - Setting bit 7 enables extra pin pull-up when reset pin disabled.
// - Extra pin used as reset keeps its pull-up always on.
// - Setting bit 3 routes timer 1 output to its pin.
// - Setting bit 2 routes timer 0 output to its pin.
// - Setting bit 0 selects Schmitt input for the extra pin.
// - Setting register resets to zero.
module ppc_top (
    // Clock, reset and the Avalon-MM slave.
    input  wire        ref_clk,
    input  wire        rst,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // Core data and configuration inputs.
    input  wire [7:0]  port0_out_data,
    input  wire [7:0]  port1_out_data,
    input  wire        reset_pin_disable_config,
    input  wire        timer0_out,
    input  wire        timer1_out,
    // Registered pad controls of both ports.
    output reg  [7:0]  port0_drive_high,
    output reg  [7:0]  port0_drive_low,
    output reg  [7:0]  port0_weak_pullup,
    output reg  [7:0]  port1_drive_high,
    output reg  [7:0]  port1_drive_low,
    output reg  [7:0]  port1_weak_pullup,
    // Registered input-type and slew selects.
    output reg  [7:0]  port0_schmitt_select,
    output reg  [7:0]  port1_schmitt_select,
    output reg  [7:0]  port0_slew_select,
    output reg  [7:0]  port1_slew_select,
    // Registered extra pin and timer pin controls.
    output reg         extra_pin_pullup_enable,
    output reg         extra_pin_schmitt_select,
    output reg         timer0_pin,
    output reg         timer0_pin_oe,
    output reg         timer1_pin,
    output reg         timer1_pin_oe
);

    // Page 0 mode registers: together they hold one mode pair per pin.
    reg  [7:0] port0_mode_a;
    reg  [7:0] port0_mode_b;
    reg  [7:0] port1_mode_a;
    reg  [7:0] port1_mode_b;

    // Page 1 input-type and slew-rate registers.
    reg  [7:0] port0_schmitt;
    reg  [7:0] port1_schmitt;
    reg  [7:0] port0_slew;
    reg  [7:0] port1_slew;

    // Extra pin setting, and the page selector that steers addresses b1 to b4.
    reg  [7:0] extra_pin_setting;
    reg        page_sel;

    // Bus handshake state and the byte that a read would return.
    reg        ack;
    reg  [7:0] next_rdata;

    // Request qualifiers and the write byte.
    wire       req;
    wire       wr_go;
    wire       lane0;
    wire [7:0] wbyte;

    // One select line per mapped byte address.
    wire       sel_p0_a;
    wire       sel_p0_b;
    wire       sel_p1_a;
    wire       sel_p1_b;
    wire       sel_extra;
    wire       sel_page;

    // Decoded pad controls of both ports, ahead of the output registers.
    wire [7:0] p0_dh;
    wire [7:0] p0_dl;
    wire [7:0] p0_wp;
    wire [7:0] p1_dh;
    wire [7:0] p1_dl;
    wire [7:0] p1_wp;

    // Decoded extra pin and timer pin controls.
    wire       x_pu;
    wire       x_st;
    wire       t0_d;
    wire       t0_e;
    wire       t1_d;
    wire       t1_e;

    // Each access is answered one cycle after it is seen; waitrequest drops for that edge.
    // A strobe is taken only while ack is low, so the completing edge never starts a
    // second access from the same strobe before the master has dropped it.
    assign req   = (avs_read | avs_write) & ~ack;
    assign wr_go = avs_write & ack;
    assign lane0 = avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];

    // Address decode; addresses outside the map select nothing.
    assign sel_p0_a  = (avs_address == `PPC_OFS_P0_MODE_A);
    assign sel_p0_b  = (avs_address == `PPC_OFS_P0_MODE_B);
    assign sel_p1_a  = (avs_address == `PPC_OFS_P1_MODE_A);
    assign sel_p1_b  = (avs_address == `PPC_OFS_P1_MODE_B);
    assign sel_extra = (avs_address == `PPC_OFS_EXTRA_SET);
    assign sel_page  = (avs_address == `PPC_OFS_PAGE_SEL);

    // Handshake state: ack marks the completing cycle of a request.
    // One access: the strobe is seen at edge N with ack low, waitrequest falls after N,
    // and the access completes at edge N+1, where the master samples it low.
    // Waitrequest rises again after N+1, so every access costs exactly one wait cycle.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            ack <= req;
            avs_waitrequest <= ~req;
        end
    end

    // Register writes; the page selector picks mode or input/slew registers.
    // A write lands only at the completing edge and only through byte lane 0.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port0_mode_a      <= `PPC_RST_MODE_A;
            port0_mode_b      <= `PPC_RST_MODE_B;
            port1_mode_a      <= `PPC_RST_MODE_A;
            port1_mode_b      <= `PPC_RST_MODE_B;
            port0_schmitt     <= `PPC_RST_SCHMITT;
            port1_schmitt     <= `PPC_RST_SCHMITT;
            port0_slew        <= `PPC_RST_SLEW;
            port1_slew        <= `PPC_RST_SLEW;
            extra_pin_setting <= `PPC_RST_EXTRA_SET;
            page_sel          <= 1'b0;
        end else if (wr_go && lane0) begin
            if (sel_p0_a) begin
                if (page_sel) begin
                    port0_schmitt <= wbyte;
                end else begin
                    port0_mode_a <= wbyte;
                end
            end else if (sel_p0_b) begin
                if (page_sel) begin
                    port0_slew <= wbyte;
                end else begin
                    port0_mode_b <= wbyte;
                end
            end else if (sel_p1_a) begin
                if (page_sel) begin
                    port1_schmitt <= wbyte;
                end else begin
                    port1_mode_a <= wbyte;
                end
            end else if (sel_p1_b) begin
                if (page_sel) begin
                    port1_slew <= wbyte;
                end else begin
                    port1_mode_b <= wbyte;
                end
            end else if (sel_extra) begin
                // Unused bits are dropped here so they can never read back as one.
                extra_pin_setting <= wbyte & `PPC_EXTRA_MASK;
            end else if (sel_page) begin
                page_sel <= wbyte[0];
            end
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    // The page selector steers addresses b1 to b4 here exactly as it does for writes.
    always @* begin
        next_rdata = 8'h00;
        if (sel_p0_a) begin
            next_rdata = page_sel ? port0_schmitt : port0_mode_a;
        end else if (sel_p0_b) begin
            next_rdata = page_sel ? port0_slew : port0_mode_b;
        end else if (sel_p1_a) begin
            next_rdata = page_sel ? port1_schmitt : port1_mode_a;
        end else if (sel_p1_b) begin
            next_rdata = page_sel ? port1_slew : port1_mode_b;
        end else if (sel_extra) begin
            next_rdata = extra_pin_setting & `PPC_EXTRA_MASK;
        end else if (sel_page) begin
            next_rdata = {7'h00, page_sel};
        end
    end

    // Read data is loaded at the edge that drops waitrequest and held afterwards.
    // Only the low byte lane carries data; the upper lanes always read as zero.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (req && avs_read) begin
            avs_readdata <= {24'h000000, next_rdata};
        end
    end

    // Port 0: each pin's mode pair decides which drivers its output data may use.
    ppc_pin_ctrl u_port0 (
        .mode_a      (port0_mode_a),
        .mode_b      (port0_mode_b),
        .out_data    (port0_out_data),
        .drive_high  (p0_dh),
        .drive_low   (p0_dl),
        .weak_pullup (p0_wp)
    );

    // Port 1: the same per-pin decode as port 0.
    ppc_pin_ctrl u_port1 (
        .mode_a      (port1_mode_a),
        .mode_b      (port1_mode_b),
        .out_data    (port1_out_data),
        .drive_high  (p1_dh),
        .drive_low   (p1_dl),
        .weak_pullup (p1_wp)
    );

    // Extra pin and timer routing; whether a timer runs in timer mode is up to software.
    ppc_extra_pin u_extra (
        .setting                  (extra_pin_setting),
        .reset_pin_disable_config (reset_pin_disable_config),
        .timer0_out               (timer0_out),
        .timer1_out               (timer1_out),
        .pullup_on                (x_pu),
        .schmitt_on               (x_st),
        .timer0_pin_drive         (t0_d),
        .timer0_pin_en            (t0_e),
        .timer1_pin_drive         (t1_d),
        .timer1_pin_en            (t1_e)
    );

    // Pad controls are registered so every output comes from a flip-flop.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            // Pads idle in reset: no drive and no pull-up on any pin.
            port0_drive_high         <= 8'h00;
            port0_drive_low          <= 8'h00;
            port0_weak_pullup        <= 8'h00;
            port1_drive_high         <= 8'h00;
            port1_drive_low          <= 8'h00;
            port1_weak_pullup        <= 8'h00;

            // Input-type and slew selects start at TTL input and normal slew.
            port0_schmitt_select     <= 8'h00;
            port1_schmitt_select     <= 8'h00;
            port0_slew_select        <= 8'h00;
            port1_slew_select        <= 8'h00;

            // Extra pin pull-up and Schmitt input start off.
            extra_pin_pullup_enable  <= 1'b0;
            extra_pin_schmitt_select <= 1'b0;

            // Timer pins start low and undriven.
            timer0_pin               <= 1'b0;
            timer0_pin_oe            <= 1'b0;
            timer1_pin               <= 1'b0;
            timer1_pin_oe            <= 1'b0;
        end else begin
            // Pad controls follow the decoded mode pair of each pin.
            port0_drive_high         <= p0_dh;
            port0_drive_low          <= p0_dl;
            port0_weak_pullup        <= p0_wp;
            port1_drive_high         <= p1_dh;
            port1_drive_low          <= p1_dl;
            port1_weak_pullup        <= p1_wp;

            // Input-type and slew selects copy the page 1 registers.
            port0_schmitt_select     <= port0_schmitt;
            port1_schmitt_select     <= port1_schmitt;
            port0_slew_select        <= port0_slew;
            port1_slew_select        <= port1_slew;

            // Extra pin pull-up and input type.
            extra_pin_pullup_enable  <= x_pu;
            extra_pin_schmitt_select <= x_st;

            // Timer pins, each gated by its output enable.
            timer0_pin               <= t0_d;
            timer0_pin_oe            <= t0_e;
            timer1_pin               <= t1_d;
            timer1_pin_oe            <= t1_e;
        end
    end

endmodule

// [testbench/ppc_pad_model.sv]
// External circuitry on one port: resolves pad controls into the level seen outside.
// Assumes active-high drive controls; a released pin with no pull-up floats.
module ppc_pad_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] drive_high,
    input  wire logic [7:0] drive_low,
    input  wire logic [7:0] weak_pullup,
    output logic      [7:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] float_pat = 8'h55;
    // A floating line shows a changing pattern so no held value can pass.
    always @(posedge ref_clk) float_pat <= ~float_pat;
    // Low drive wins, then high drive or weak pull-up, else the line floats.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_level[i] = drive_low[i] ? 1'b0 : (drive_high[i] | weak_pullup[i]) ? 1'b1
                         : float_pat[i];
        end
    end
endmodule

// [testbench/ppc_top_sva.sv]
// Concurrent checks on the port pin configuration block's top-level ports.
// Assumes one clock domain and a registered, one-cycle lag on every output.
module ppc_top_sva (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [7:0]  port0_drive_high,
    input wire logic [7:0]  port0_drive_low,
    input wire logic [7:0]  port0_weak_pullup,
    input wire logic [7:0]  port1_drive_low,
    input wire logic [7:0]  port1_weak_pullup,
    input wire logic [7:0]  port0_schmitt_select,
    input wire logic [7:0]  port1_slew_select,
    input wire logic        extra_pin_pullup_enable,
    input wire logic        extra_pin_schmitt_select,
    input wire logic        reset_pin_disable_config,
    input wire logic        timer0_out,
    input wire logic        timer1_out,
    input wire logic        timer0_pin,
    input wire logic        timer0_pin_oe,
    input wire logic        timer1_pin,
    input wire logic        timer1_pin_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Just after reset every pin is input-only, so nothing drives or pulls.
    property p_p0_rst; $past(rst) |-> (port0_drive_low | port0_weak_pullup) == 8'h00; endproperty
    a_p0_rst: assert property (p_p0_rst) else $error("port 0 pads active after reset");
    property p_p1_rst; $past(rst) |-> (port1_drive_low | port1_weak_pullup) == 8'h00; endproperty
    a_p1_rst: assert property (p_p1_rst) else $error("port 1 pads active after reset");
    property p_sel_rst; $past(rst) |-> (port0_schmitt_select | port1_slew_select) == 8'h00;
    endproperty
    a_sel_rst: assert property (p_sel_rst) else $error("select outputs set after reset");
    property p_ext_rst; $past(rst) |-> !(extra_pin_schmitt_select | timer0_pin_oe | timer1_pin_oe);
    endproperty
    a_ext_rst: assert property (p_ext_rst) else $error("extra setting set after reset");
    // A port 0 pin is never pushed high and pulled low at once.
    property p_no_fight; (port0_drive_high & port0_drive_low) == 8'h00; endproperty
    a_no_fight: assert property (p_no_fight) else $error("port 0 drives both ways");
    // Timer pins follow the timer outputs only while routed.
    property p_t0_route; timer0_pin == (timer0_pin_oe & $past(timer0_out)); endproperty
    a_t0_route: assert property (p_t0_route) else $error("timer 0 pin wrong");
    property p_t1_route; timer1_pin == (timer1_pin_oe & $past(timer1_out)); endproperty
    a_t1_route: assert property (p_t1_route) else $error("timer 1 pin wrong");
    property p_rp_pullup; reset_pin_disable_config |=> extra_pin_pullup_enable; endproperty
    a_rp_pullup: assert property (p_rp_pullup) else $error("reset pin pull-up off");
    property p_rsvd;
        avs_read && !avs_waitrequest && avs_address == 8'hb5 |-> !(avs_readdata & 32'hffffff72);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("unused setting bits read nonzero");
endmodule
bind ppc_top ppc_top_sva i_sva (.*);

// [testbench/tb.sv]
// Self-checking bench for the port pin configuration block over Avalon-MM.
// Assumes one wait cycle per access and outputs that lag their cause by one clock.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, rst = 1, avs_read = 0, avs_write = 0, reset_pin_disable_config = 0;
    logic timer0_out = 0, timer1_out = 0;
    logic [7:0]  avs_address = 8'h00, port0_out_data = 8'h00, port1_out_data = 8'h00;
    logic [31:0] avs_writedata = 32'h0, rd;
    logic [3:0]  avs_byteenable = 4'h1;
    wire [31:0]  avs_readdata;
    wire avs_waitrequest, extra_pin_pullup_enable, extra_pin_schmitt_select;
    wire timer0_pin, timer0_pin_oe, timer1_pin, timer1_pin_oe;
    wire [7:0] port0_drive_high, port0_drive_low, port0_weak_pullup, port1_drive_high;
    wire [7:0] port1_drive_low, port1_weak_pullup, port0_schmitt_select, port1_schmitt_select;
    wire [7:0] port0_slew_select, port1_slew_select, pin0, pin1;
    int n_errors = 0, check_count = 0;
    ppc_top i_dut (.*);
    ppc_pad_model i_pad0 (.ref_clk(ref_clk), .drive_high(port0_drive_high),
        .drive_low(port0_drive_low), .weak_pullup(port0_weak_pullup), .pin_level(pin0));
    ppc_pad_model i_pad1 (.ref_clk(ref_clk), .drive_high(port1_drive_high),
        .drive_low(port1_drive_low), .weak_pullup(port1_weak_pullup), .pin_level(pin1));
    // The clock runs at 10 MHz.
    initial forever #50 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), rd, {24'h0, e});
    endtask
    // Waits until a change made at this edge shows at the outputs.
    task automatic settle();
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic pads(input logic [7:0] wm, input logic [7:0] pm, input logic [31:0] e);
        chk("port0 pads", {port0_drive_high, port0_drive_low, port0_weak_pullup & wm,
            pin0 & pm}, e);
        chk("port1 pads", {port1_drive_high, port1_drive_low, port1_weak_pullup & wm,
            pin1 & pm}, e);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // The tests need a few hundred cycles; 10000 cycles means a hang.
    initial begin
        #1000000;
        n_errors++;
        end_sim();
    end
    // Main sequence of tests.
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        settle();
        pads(8'hff, 8'h00, 32'h0);
        chk("selects", {port0_schmitt_select, port1_schmitt_select, port0_slew_select,
            port1_slew_select}, 32'h0);
        chk("extra", {extra_pin_pullup_enable, extra_pin_schmitt_select, timer0_pin_oe,
            timer1_pin_oe}, 4'h0);
        for (int i = 0; i < 4; i++) rdc(8'hb1 + 8'(i), i[0] ? 8'h00 : 8'hff);
        bus(1'b1, 8'hb6, 8'h01);
        for (int i = 0; i < 4; i++) rdc(8'hb1 + 8'(i), 8'h00);
        rdc(8'hb5, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 4; i++) bus(1'b1, 8'hb1 + 8'(i), 8'h11 * 8'(i + 1));
        for (int i = 0; i < 4; i++) rdc(8'hb1 + 8'(i), 8'h11 * 8'(i + 1));
        settle();
        chk("selects", {port0_schmitt_select, port0_slew_select, port1_schmitt_select,
            port1_slew_select}, 32'h11223344);
        bus(1'b1, 8'hb6, 8'h00);
        for (int i = 0; i < 4; i++) rdc(8'hb1 + 8'(i), i[0] ? 8'h00 : 8'hff);
        bus(1'b1, 8'hb7, 8'h5a);
        rdc(8'hb7, 8'h00);
        $display("paging test done");
        for (int i = 0; i < 4; i++) bus(1'b1, 8'hb1 + 8'(i), i[0] ? 8'haa : 8'hcc);
        port0_out_data <= 8'hff;
        port1_out_data <= 8'hff;
        settle();
        pads(8'hff, 8'h33, 32'h22001133);
        port0_out_data <= 8'h00;
        port1_out_data <= 8'h00;
        settle();
        pads(8'h00, 8'hbb, 32'h00bb0000);
        $display("mode test done");
        timer0_out <= 1'b1;
        bus(1'b1, 8'hb5, 8'hff);
        rdc(8'hb5, 8'h8d);
        settle();
        chk("extra", {extra_pin_pullup_enable, extra_pin_schmitt_select, timer0_pin,
            timer0_pin_oe, timer1_pin, timer1_pin_oe}, 6'b111101);
        timer0_out <= 1'b0;
        timer1_out <= 1'b1;
        settle();
        chk("timers", {timer0_pin, timer0_pin_oe, timer1_pin, timer1_pin_oe}, 4'b0111);
        bus(1'b1, 8'hb5, 8'h00);
        reset_pin_disable_config <= 1'b1;
        settle();
        chk("extra", {extra_pin_pullup_enable, extra_pin_schmitt_select, timer1_pin,
            timer1_pin_oe}, 4'b1000);
        reset_pin_disable_config <= 1'b0;
        settle();
        chk("pullup", extra_pin_pullup_enable, 1'b0);
        rst <= 1'b1;
        settle();
        rst <= 1'b0;
        rdc(8'hb1, 8'hff);
        $display("extra pin test done");
        end_sim();
    end
endmodule
